// ### logic/rd_slave_pkg.sv
// Shared constants for the memory-mapped read and write-response slave.
package rd_slave_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_EXOKAY = 2'h1;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Burst types.
	localparam logic [1:0] BURST_FIXED = 2'h0;
	localparam logic [1:0] BURST_INCR  = 2'h1;
	localparam logic [1:0] BURST_WRAP  = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and limits.
	localparam int MIN_ADDR_W     = 32;
	localparam int MIN_DATA_W     = 32;
	localparam int MAX_DATA_W     = 256;
	localparam int LITE_DATA_W    = 32;
	localparam int MIN_BEAT_BITS  = 8;
	localparam int MAX_BEAT_BITS  = 256;
	localparam int MAX_INCR_BEATS = 256;
	localparam int WRAP_BEATS     = 16;
	localparam int LEN_W          = 8;
	localparam int SIZE_W         = 3;
	localparam int FIFO_DEPTH     = 8;

	////////////////////////////////////////////////////////////////////////////////
	// Reset timing.
	localparam int CLK_PERIOD_NS     = 25;
	localparam int VALID_DROP_CYCLES = 8;
	localparam int RESET_HOLD_CYCLES = 16;
	localparam int RESET_SYNC_STAGES = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values.
	localparam logic [1:0] RST_STATE = 2'h1;

endpackage : rd_slave_pkg

// ### logic/beat_if.sv
// Carrier for read data beats between the burst engine and the beat FIFO.
`timescale 1ns/1ps
interface beat_if #(
	parameter int WIDTH = 8
);
	// Filling side.
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	// Draining side.
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;

	modport fifo (
		input  in_valid,
		output in_ready,
		input  in_data,
		output out_valid,
		input  out_ready,
		output out_data
	);

	modport user (
		output in_valid,
		input  in_ready,
		output in_data,
		input  out_valid,
		output out_ready,
		input  out_data
	);
endinterface : beat_if

// ### logic/beat_fifo.sv
// Synchronous FIFO holding read data beats on their way to the read data channel.
`timescale 1ns/1ps
module beat_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset.
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	// Beat carrier.
	beat_if.fifo      port_if
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] store_ff [DEPTH];
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] nxt_wr_ptr;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [PTR_W-1:0] nxt_rd_ptr;
	logic [CNT_W-1:0] count_ff;
	logic [CNT_W-1:0] nxt_count;
	logic             push;
	logic             pop;

	function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
		if (p == PTR_W'(DEPTH - 1)) begin
			bump = '0;
		end else begin
			bump = p + PTR_W'(1);
		end
	endfunction : bump

	////////////////////////////////////////////////////////////////////////////////
	// Flags and pointer arithmetic.
	assign port_if.in_ready  = (count_ff != CNT_W'(DEPTH));
	assign port_if.out_valid = (count_ff != '0);
	assign port_if.out_data  = store_ff[rd_ptr_ff];
	assign push = port_if.in_valid && port_if.in_ready;
	assign pop  = port_if.out_valid && port_if.out_ready;

	always_comb begin
		nxt_wr_ptr = push ? bump(wr_ptr_ff) : wr_ptr_ff;
		nxt_rd_ptr = pop ? bump(rd_ptr_ff) : rd_ptr_ff;
		nxt_count  = count_ff;
		if (push && !pop) begin
			nxt_count = count_ff + CNT_W'(1);
		end else if (pop && !push) begin
			nxt_count = count_ff - CNT_W'(1);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			count_ff  <= nxt_count;
		end
	end

	// Storage has no reset; only words below the count are ever read.
	always_ff @(posedge clock_i) begin
		if (push) begin
			store_ff[wr_ptr_ff] <= port_if.in_data;
		end
	end

endmodule : beat_fifo

// ### logic/mm_rd_slave.sv
// Memory-mapped endpoint slave: read address, read data and write response channels.
`timescale 1ns/1ps
module mm_rd_slave #(
	parameter int  ADDR_W   = rd_slave_pkg::MIN_ADDR_W,
	parameter int  DATA_W   = rd_slave_pkg::MIN_DATA_W,
	parameter int  ID_W     = 4,
	parameter int  LOCAL_AW = 12,
	parameter int  REGION_W = 4,
	parameter bit  LITE     = 1'b0,
	parameter bit  HAS_READ = 1'b1,
	parameter bit  HAS_WR   = 1'b1,
	parameter int  FIFO_D   = rd_slave_pkg::FIFO_DEPTH
) (
	// Clock and reset.
	input  wire logic                clock_i,
	input  wire logic                arst_n_i,
	// Read address channel.
	input  wire logic [ID_W-1:0]     arid_i,
	input  wire logic [ADDR_W-1:0]   araddr_i,
	input  wire logic [7:0]          arlen_i,
	input  wire logic [2:0]          arsize_i,
	input  wire logic [1:0]          arburst_i,
	input  wire logic                arlock_i,
	input  wire logic [3:0]          arcache_i,
	input  wire logic [2:0]          arprot_i,
	input  wire logic [3:0]          arqos_i,
	input  wire logic [REGION_W-1:0] arregion_i,
	input  wire logic                arvalid_i,
	output logic                     arready_o,
	// Read data channel.
	output logic [ID_W-1:0]          rid_o,
	output logic [DATA_W-1:0]        rdata_o,
	output logic [1:0]               rresp_o,
	output logic                     rlast_o,
	output logic                     rvalid_o,
	input  wire logic                rready_i,
	// Write response channel.
	output logic [ID_W-1:0]          bid_o,
	output logic [1:0]               bresp_o,
	output logic                     bvalid_o,
	input  wire logic                bready_i,
	// Completed writes from the write address and data logic.
	input  wire logic                wr_done_i,
	input  wire logic [ID_W-1:0]     wr_id_i,
	input  wire logic [1:0]          wr_resp_i,
	output logic                     wr_done_ready_o,
	// Memory fill port from the write data logic.
	input  wire logic                mem_wr_en_i,
	input  wire logic [LOCAL_AW-1:0] mem_wr_addr_i,
	input  wire logic [DATA_W-1:0]   mem_wr_data_i
);

	localparam int BYTES   = DATA_W / 8;
	localparam int LANE_W  = $clog2(BYTES);
	localparam int WORDS   = 2 ** (LOCAL_AW - LANE_W);
	localparam int BEAT_W  = ID_W + DATA_W + 1;
	localparam int SPAN_W  = LOCAL_AW + 1;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_BURST = 2'b10
	} rd_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// Reset release through two flip-flops.
	logic rst_meta_ff;
	logic rst_n_ff;

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Memory behind the slave.
	logic [DATA_W-1:0] mem_ff [WORDS];

	always_ff @(posedge clock_i) begin
		if (mem_wr_en_i) begin
			mem_ff[mem_wr_addr_i[LOCAL_AW-1:LANE_W]] <= mem_wr_data_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Address step for one beat; fixed bursts step like incrementing ones.
	function automatic logic [LOCAL_AW-1:0] step_addr(
		input logic [LOCAL_AW-1:0] addr,
		input logic [2:0]          size,
		input logic [7:0]          len,
		input logic [1:0]          burst
	);
		logic [SPAN_W-1:0] inc;
		logic [SPAN_W-1:0] span;
		logic [SPAN_W-1:0] mask;
		logic [SPAN_W-1:0] sum;
		inc  = SPAN_W'(1) << size;
		span = SPAN_W'(inc * (SPAN_W'(len) + SPAN_W'(1)));
		mask = span - SPAN_W'(1);
		sum  = SPAN_W'(addr) + inc;
		if (burst == rd_slave_pkg::BURST_WRAP) begin
			step_addr = LOCAL_AW'((SPAN_W'(addr) & ~mask) | (sum & mask));
		end else begin
			step_addr = sum[LOCAL_AW-1:0];
		end
	endfunction : step_addr

	////////////////////////////////////////////////////////////////////////////////
	// Burst engine: takes one read request, pushes its beats into the FIFO.
	beat_if #(.WIDTH(BEAT_W)) beats ();

	rd_state_t             state_ff;
	rd_state_t             nxt_state;
	logic                  arready_ff;
	logic                  nxt_arready;
	logic [LOCAL_AW-1:0]   addr_ff;
	logic [LOCAL_AW-1:0]   nxt_addr;
	logic [7:0]            len_ff;
	logic [7:0]            nxt_len;
	logic [7:0]            left_ff;
	logic [7:0]            nxt_left;
	logic [2:0]            size_ff;
	logic [2:0]            nxt_size;
	logic [1:0]            burst_ff;
	logic [1:0]            nxt_burst;
	logic [ID_W-1:0]       id_ff;
	logic [ID_W-1:0]       nxt_id;

	// Lock, cache, protection, QoS and region are accepted and ignored.
	always_comb begin
		nxt_state   = state_ff;
		nxt_addr    = addr_ff;
		nxt_len     = len_ff;
		nxt_left    = left_ff;
		nxt_size    = size_ff;
		nxt_burst   = burst_ff;
		nxt_id      = id_ff;
		beats.in_valid = 1'b0;
		beats.in_data  = {id_ff, mem_ff[addr_ff[LOCAL_AW-1:LANE_W]], left_ff == 8'h00};
		case (state_ff)
			ST_IDLE: begin
				if (arvalid_i && arready_ff) begin
					nxt_state = ST_BURST;
					nxt_addr  = araddr_i[LOCAL_AW-1:0];
					if (LITE) begin
						nxt_len   = 8'h00;
						nxt_size  = 3'(LANE_W);
						nxt_burst = rd_slave_pkg::BURST_INCR;
						nxt_id    = '0;
					end else begin
						nxt_len   = arlen_i;
						nxt_size  = arsize_i;
						nxt_burst = arburst_i;
						nxt_id    = arid_i;
					end
					nxt_left = nxt_len;
				end
			end
			ST_BURST: begin
				beats.in_valid = 1'b1;
				if (beats.in_ready) begin
					if (left_ff == 8'h00) begin
						nxt_state = ST_IDLE;
					end else begin
						nxt_left = left_ff - 8'h01;
						nxt_addr = step_addr(addr_ff, size_ff, len_ff, burst_ff);
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		nxt_arready = HAS_READ && (nxt_state == ST_IDLE);
	end

	always_ff @(posedge clock_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			state_ff   <= rd_state_t'(rd_slave_pkg::RST_STATE);
			arready_ff <= 1'b0;
			addr_ff    <= '0;
			len_ff     <= 8'h00;
			left_ff    <= 8'h00;
			size_ff    <= 3'h0;
			burst_ff   <= rd_slave_pkg::BURST_INCR;
			id_ff      <= '0;
		end else begin
			state_ff   <= nxt_state;
			arready_ff <= nxt_arready;
			addr_ff    <= nxt_addr;
			len_ff     <= nxt_len;
			left_ff    <= nxt_left;
			size_ff    <= nxt_size;
			burst_ff   <= nxt_burst;
			id_ff      <= nxt_id;
		end
	end

	beat_fifo #(
		.WIDTH (BEAT_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clock_i (clock_i),
		.rst_n_i (rst_n_ff),
		.port_if (beats)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read data output stage: reloads whenever empty or drained by the master.
	logic [ID_W-1:0]   rid_ff;
	logic [ID_W-1:0]   nxt_rid;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic              rlast_ff;
	logic              nxt_rlast;
	logic              rvalid_ff;
	logic              nxt_rvalid;

	assign beats.out_ready = !rvalid_ff || rready_i;

	always_comb begin
		nxt_rid    = rid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rlast  = rlast_ff;
		nxt_rvalid = rvalid_ff;
		if (beats.out_ready) begin
			nxt_rvalid = beats.out_valid;
			if (beats.out_valid) begin
				nxt_rid   = beats.out_data[BEAT_W-1 -: ID_W];
				nxt_rdata = beats.out_data[DATA_W:1];
				nxt_rlast = LITE ? 1'b0 : beats.out_data[0];
			end
		end
	end

	// The slower reset release would let valid linger; the raw reset clears it at once.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rid_ff    <= '0;
			rdata_ff  <= '0;
			rlast_ff  <= 1'b0;
			rvalid_ff <= 1'b0;
		end else if (!rst_n_ff) begin
			rvalid_ff <= 1'b0;
		end else begin
			rid_ff    <= nxt_rid;
			rdata_ff  <= nxt_rdata;
			rlast_ff  <= nxt_rlast;
			rvalid_ff <= nxt_rvalid;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Write response: one response held until the master takes it.
	logic [ID_W-1:0] bid_ff;
	logic [ID_W-1:0] nxt_bid;
	logic [1:0]      bresp_ff;
	logic [1:0]      nxt_bresp;
	logic            bvalid_ff;
	logic            nxt_bvalid;
	logic            wr_rdy_ff;
	logic            nxt_wr_rdy;

	always_comb begin
		nxt_bid    = bid_ff;
		nxt_bresp  = bresp_ff;
		nxt_bvalid = bvalid_ff;
		if (bvalid_ff && bready_i) begin
			nxt_bvalid = 1'b0;
		end
		if (HAS_WR && wr_done_i && wr_rdy_ff) begin
			nxt_bvalid = 1'b1;
			nxt_bid    = LITE ? '0 : wr_id_i;
			nxt_bresp  = wr_resp_i;
			if (LITE && wr_resp_i == rd_slave_pkg::RESP_EXOKAY) begin
				nxt_bresp = rd_slave_pkg::RESP_OKAY;
			end
		end
		nxt_wr_rdy = HAS_WR && !nxt_bvalid;
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			bid_ff    <= '0;
			bresp_ff  <= rd_slave_pkg::RESP_OKAY;
			bvalid_ff <= 1'b0;
			wr_rdy_ff <= 1'b0;
		end else if (!rst_n_ff) begin
			bvalid_ff <= 1'b0;
			wr_rdy_ff <= 1'b0;
		end else begin
			bid_ff    <= nxt_bid;
			bresp_ff  <= nxt_bresp;
			bvalid_ff <= nxt_bvalid;
			wr_rdy_ff <= nxt_wr_rdy;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs; no user sideband is produced, read response is always okay.
	assign arready_o       = arready_ff;
	assign rid_o           = rid_ff;
	assign rdata_o         = rdata_ff;
	assign rresp_o         = rd_slave_pkg::RESP_OKAY;
	assign rlast_o         = rlast_ff;
	assign rvalid_o        = rvalid_ff;
	assign bid_o           = bid_ff;
	assign bresp_o         = bresp_ff;
	assign bvalid_o        = bvalid_ff;
	assign wr_done_ready_o = wr_rdy_ff;

endmodule : mm_rd_slave

// ### tb/mm_rd_monitor.sv
// Checker for the read and write-response slave ports.
`timescale 1ns/1ps
module mm_rd_monitor #(
	parameter int ID_W   = 4,
	parameter int DATA_W = 32
) (
	// Clock, reset and read address.
	input wire logic              clock_i,
	input wire logic              arst_n_i,
	input wire logic [ID_W-1:0]   arid_i,
	input wire logic [7:0]        arlen_i,
	input wire logic              arvalid_i,
	input wire logic              arready_o,
	// Read data.
	input wire logic [ID_W-1:0]   rid_o,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic [1:0]        rresp_o,
	input wire logic              rlast_o,
	input wire logic              rvalid_o,
	input wire logic              rready_i,
	// Write response.
	input wire logic [ID_W-1:0]   bid_o,
	input wire logic [1:0]        bresp_o,
	input wire logic              bvalid_o,
	input wire logic              bready_i,
	input wire logic              wr_done_i,
	input wire logic [ID_W-1:0]   wr_id_i,
	input wire logic [1:0]        wr_resp_i,
	input wire logic              wr_done_ready_o
);
	logic [9:0]      left_ff;
	logic [ID_W-1:0] id_ff;
	logic            ok_ff;
	wire logic       ar_hs = arvalid_i && arready_o;
	wire logic       r_hs  = rvalid_o && rready_i;

	// Beats still owed, the ID of the latest request, and whether nothing was owed when it was taken.
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			left_ff <= 10'h0;
			id_ff   <= '0;
			ok_ff   <= 1'b0;
		end else begin
			left_ff <= left_ff + (ar_hs ? {2'h0, arlen_i} + 10'h1 : 10'h0) - {9'h0, r_hs};
			if (ar_hs) begin
				id_ff <= arid_i;
				ok_ff <= left_ff == {9'h0, r_hs};
			end
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);

	sequence ar_take;
		arvalid_i && arready_o;
	endsequence
	sequence wr_take;
		wr_done_i && wr_done_ready_o;
	endsequence

	a_valid_reset_low: assert property (disable iff (1'b0) !arst_n_i |-> !rvalid_o && !bvalid_o)
		else $error("valid output high during reset");
	a_ready_release: assert property ($rose(arst_n_i) |-> !arready_o [*3] ##1 arready_o)
		else $error("address ready not raised on the third edge after reset");
	a_ar_one_open: assert property (ar_take |=> !arready_o)
		else $error("address ready stayed high after a request");
	a_rid_echo: assert property (rvalid_o && ok_ff |-> rid_o == id_ff)
		else $error("read beat carries a wrong id");
	a_rlast_final: assert property (rvalid_o && ok_ff |-> rlast_o == (left_ff == 10'h1))
		else $error("last flag not on the final beat only");
	a_beat_owed: assert property (rvalid_o |-> left_ff != 10'h0)
		else $error("read beat beyond the burst length");
	a_rdata_hold: assert property (rvalid_o && !rready_i |=>
		rvalid_o && $stable(rdata_o) && $stable(rid_o) && $stable(rlast_o))
		else $error("read beat changed while stalled");
	a_rresp_okay: assert property (rvalid_o |-> rresp_o == rd_slave_pkg::RESP_OKAY)
		else $error("read response not okay");
	a_bid_echo: assert property (wr_take |=>
		bvalid_o && bid_o == $past(wr_id_i) && bresp_o == $past(wr_resp_i))
		else $error("write response id or code wrong");
	a_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable({bid_o, bresp_o}))
		else $error("write response changed while stalled");
	a_one_wr_open: assert property (bvalid_o |-> !wr_done_ready_o)
		else $error("completion accepted with a response pending");
endmodule : mm_rd_monitor

bind mm_rd_slave mm_rd_monitor #(.ID_W(ID_W), .DATA_W(DATA_W)) mm_rd_monitor_i (.*);

// ### tb/rd_master.sv
// Master model issuing read requests and taking read beats and write responses.
`timescale 1ns/1ps
module rd_master (
	// Clock.
	input wire logic        clock_i,
	// Read address channel.
	output logic [3:0]      arid_o,
	output logic [31:0]     araddr_o,
	output logic [7:0]      arlen_o,
	output logic [2:0]      arsize_o,
	output logic [1:0]      arburst_o,
	output logic            arlock_o,
	output logic [3:0]      arcache_o,
	output logic [2:0]      arprot_o,
	output logic [3:0]      arqos_o,
	output logic [3:0]      arregion_o,
	output logic            arvalid_o,
	input wire logic        arready_i,
	// Read data channel.
	input wire logic [3:0]  rid_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0]  rresp_i,
	input wire logic        rlast_i,
	input wire logic        rvalid_i,
	output logic            rready_o,
	// Write response channel.
	input wire logic [3:0]  bid_i,
	input wire logic [1:0]  bresp_i,
	input wire logic        bvalid_i,
	output logic            bready_o
);
	logic [3:0]  got_id[$];
	logic [31:0] got_data[$];
	logic        got_last[$];
	logic [1:0]  got_resp[$];
	logic [5:0]  got_b;

	initial begin
		{arid_o, araddr_o, arlen_o, arsize_o, arburst_o, arlock_o} = '0;
		{arqos_o, arregion_o, arvalid_o, rready_o, bready_o} = '0;
		arcache_o = 4'h3;
		arprot_o = 3'h0;
	end

	// Whole-word beats only; odd sets lock, qos and region that the slave must ignore.
	task automatic read(input logic [3:0] id, input logic [31:0] addr, input logic [7:0] len,
			input logic [1:0] burst, input logic odd, input int stall);
		int w;
		got_id.delete();
		got_data.delete();
		got_last.delete();
		got_resp.delete();
		@(negedge clock_i);
		arid_o = id;
		araddr_o = addr;
		arlen_o = len;
		arsize_o = 3'h2;
		arburst_o = burst;
		arlock_o = odd;
		arqos_o = {4{odd}};
		arregion_o = {2'h0, odd, odd};
		arvalid_o = 1'b1;
		w = 0;
		do begin
			@(posedge clock_i);
			w++;
		end while (!arready_i && w < 100);
		@(negedge clock_i);
		arvalid_o = 1'b0;
		araddr_o = ~addr;
		arid_o = ~id;
		arlen_o = ~len;
		repeat (stall) @(negedge clock_i);
		rready_o = 1'b1;
		w = 0;
		while (got_id.size() <= int'(len) && w < 1000) begin
			@(posedge clock_i);
			w++;
			if (rvalid_i) begin
				got_id.push_back(rid_i);
				got_data.push_back(rdata_i);
				got_last.push_back(rlast_i);
				got_resp.push_back(rresp_i);
			end
		end
		@(negedge clock_i);
		rready_o = 1'b0;
	endtask : read

	task automatic take_resp(input int stall);
		int w;
		repeat (stall) @(negedge clock_i);
		bready_o = 1'b1;
		w = 0;
		do begin
			@(posedge clock_i);
			w++;
		end while (!bvalid_i && w < 100);
		got_b = {bid_i, bresp_i};
		@(negedge clock_i);
		bready_o = 1'b0;
	endtask : take_resp
endmodule : rd_master

// ### tb/mm_rd_slave_tb.sv
// Self-checking bench for the read and write-response slave.
`timescale 1ns/1ps
module mm_rd_slave_tb;
	logic        clock_i = 1'b1;
	logic        arst_n_i = 1'b1;
	logic [31:0] araddr_i, rdata_o, mem_wr_data_i;
	logic [11:0] mem_wr_addr_i;
	logic [7:0]  arlen_i;
	logic [3:0]  arid_i, arcache_i, arqos_i, arregion_i, rid_o, bid_o, wr_id_i;
	logic [2:0]  arsize_i, arprot_i;
	logic [1:0]  arburst_i, rresp_o, bresp_o, wr_resp_i;
	logic        arlock_i, arvalid_i, arready_o, rlast_o, rvalid_o, rready_i;
	logic        bvalid_o, bready_i, wr_done_i, wr_done_ready_o, mem_wr_en_i;
	int          n_fail = 0;
	int          total_checks = 0;
	int          cycles = 0;

	always #(rd_slave_pkg::CLK_PERIOD_NS / 2.0) clock_i = ~clock_i;

	mm_rd_slave mm_rd_slave_i (.*);

	rd_master rd_master_i (.clock_i(clock_i), .arid_o(arid_i), .araddr_o(araddr_i),
		.arlen_o(arlen_i), .arsize_o(arsize_i), .arburst_o(arburst_i), .arlock_o(arlock_i),
		.arcache_o(arcache_i), .arprot_o(arprot_i), .arqos_o(arqos_i),
		.arregion_o(arregion_i), .arvalid_o(arvalid_i), .arready_i(arready_o),
		.rid_i(rid_o), .rdata_i(rdata_o), .rresp_i(rresp_o), .rlast_i(rlast_o),
		.rvalid_i(rvalid_o), .rready_o(rready_i), .bid_i(bid_o), .bresp_i(bresp_o),
		.bvalid_i(bvalid_o), .bready_o(bready_i));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : check

	task automatic print_verdict();
		if (n_fail == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	function automatic logic [31:0] word(input logic [9:0] idx);
		return {16'ha5c3, 6'h0, idx};
	endfunction : word

	task automatic verify(input logic [3:0] id, input logic [11:0] a, input logic [7:0] len,
			input logic [1:0] burst);
		logic [11:0] span;
		logic [11:0] base;
		logic [11:0] ad;
		span = ({4'h0, len} + 12'h1) << 2;
		base = a & ~(span - 12'h1);
		check(64'(rd_master_i.got_id.size()), 64'(len) + 64'h1, "beat count");
		for (int k = 0; k <= int'(len); k++) begin
			ad = (burst == rd_slave_pkg::BURST_WRAP) ?
				base + ((a - base + 12'(k * 4)) % span) : a + 12'(k * 4);
			check(64'(rd_master_i.got_data[k]), 64'(word(ad[11:2])), "data");
			check(64'(rd_master_i.got_id[k]), 64'(id), "id");
			check(64'(rd_master_i.got_last[k]), 64'(k == int'(len)), "last");
			check(64'(rd_master_i.got_resp[k]), 64'h0, "resp");
		end
	endtask : verify

	task automatic t_reset_hold();
		arst_n_i = 1'b0;
		repeat (rd_slave_pkg::RESET_HOLD_CYCLES) @(negedge clock_i);
		check(64'({rvalid_o, bvalid_o, arready_o, wr_done_ready_o}), 64'h0, "idle");
		arst_n_i = 1'b1;
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		check(64'({arready_o, wr_done_ready_o}), 64'h3, "ready after reset");
	endtask : t_reset_hold

	task automatic t_fill();
		for (int i = 0; i < 32; i++) begin
			@(negedge clock_i);
			mem_wr_en_i = 1'b1;
			mem_wr_addr_i = 12'(i * 4);
			mem_wr_data_i = word(10'(i));
		end
		@(negedge clock_i);
		mem_wr_en_i = 1'b0;
	endtask : t_fill

	task automatic send_done(input logic [3:0] id, input logic [1:0] resp);
		int w;
		@(negedge clock_i);
		{wr_done_i, wr_id_i, wr_resp_i} = {1'b1, id, resp};
		w = 0;
		do begin
			@(posedge clock_i);
			w++;
		end while (!wr_done_ready_o && w < 100);
		@(negedge clock_i);
		{wr_done_i, wr_id_i, wr_resp_i} = {1'b0, ~id, ~resp};
	endtask : send_done

	task automatic t_wr_resp();
		send_done(4'h9, rd_slave_pkg::RESP_SLVERR);
		rd_master_i.take_resp(3);
		check(64'(rd_master_i.got_b), 64'({4'h9, rd_slave_pkg::RESP_SLVERR}), "bresp");
		send_done(4'h2, rd_slave_pkg::RESP_OKAY);
		rd_master_i.take_resp(0);
		check(64'(rd_master_i.got_b), 64'({4'h2, rd_slave_pkg::RESP_OKAY}), "bresp");
	endtask : t_wr_resp

	task automatic t_mid_reset();
		fork
			rd_master_i.read(4'h6, 32'h0, 8'h7, rd_slave_pkg::BURST_INCR, 1'b0, 40);
		join_none
		repeat (6) @(negedge clock_i);
		check(64'(rvalid_o), 64'h1, "beat waiting");
		arst_n_i = 1'b0;
		repeat (rd_slave_pkg::VALID_DROP_CYCLES) @(posedge clock_i);
		@(negedge clock_i);
		check(64'({rvalid_o, arready_o}), 64'h0, "valid dropped");
		t_reset_hold();
		wait fork;
	endtask : t_mid_reset

	initial begin
		{wr_done_i, wr_id_i, wr_resp_i, mem_wr_en_i, mem_wr_addr_i, mem_wr_data_i} = '0;
		// Reset is asserted on the first falling edge, so that no rising edge sees unset flops.
		@(negedge clock_i);
		t_reset_hold();
		t_fill();
		rd_master_i.read(4'h5, 32'hfff0_0010, 8'h3, rd_slave_pkg::BURST_INCR, 1'b0, 0);
		verify(4'h5, 12'h010, 8'h3, rd_slave_pkg::BURST_INCR);
		rd_master_i.read(4'ha, 32'h0, 8'hf, rd_slave_pkg::BURST_INCR, 1'b0, 24);
		verify(4'ha, 12'h000, 8'hf, rd_slave_pkg::BURST_INCR);
		rd_master_i.read(4'h7, 32'h40, 8'h1, rd_slave_pkg::BURST_FIXED, 1'b0, 2);
		verify(4'h7, 12'h040, 8'h1, rd_slave_pkg::BURST_FIXED);
		rd_master_i.read(4'hf, 32'h7c, 8'h0, rd_slave_pkg::BURST_INCR, 1'b1, 1);
		verify(4'hf, 12'h07c, 8'h0, rd_slave_pkg::BURST_INCR);
		t_wr_resp();
		t_mid_reset();
		t_fill();
		rd_master_i.read(4'h3, 32'h28, 8'hf, rd_slave_pkg::BURST_WRAP, 1'b0, 0);
		verify(4'h3, 12'h028, 8'hf, rd_slave_pkg::BURST_WRAP);
		print_verdict();
	end
endmodule : mm_rd_slave_tb
